// *** core/beacon_pkg.sv ***
// beacon_pkg: constants, register map and state type of the beacon sequencer
// assumes a 100 MHz system clock and an AXI4-Lite register master
// Operation
// - a message is 162 symbols, each valued 0 to 3
// - tone is base frequency plus symbol times 12000/8192 Hz
// - each symbol lasts the reciprocal of the spacing, about 0.683 s
// - weak-signal messages begin only on an even minute
// - messages repeat once per repeat interval in minutes
// - configured frequency is tone 0 with no correction term
// - pps pulse measures the clock to correct reference error
// - gps sets the clock and yields the four-character locator
// - gps data is taken only after a message, never during
// - reference measured in a 4 s window after message end
// - all post-message work ends within 7 s
// - enabled beacon starts at power-up and on menu exit
// - exit stops the beacon at once, even mid-message
// - keyed mode repeats stored message 1 at keying speed on schedule; the code instead sends the symbol FIFO contents, which each message empties
// - during a message show tone-0 frequency, symbol index and tone
// - between messages show clock time and next start minute
// - first message at start offset, later ones an interval apart
// - clock setting loads hours and minutes and clears seconds
package beacon_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ    = 100_000_000;
	localparam int TONE_NUM  = 12000;       // spacing numerator, Hz
	localparam int TONE_DEN  = 8192;        // spacing denominator
	localparam int DEN_SHIFT = 13;          // log2 of TONE_DEN
	localparam int SYM_COUNT = 162;
	localparam int SYM_CYC   = int'(longint'(CLK_HZ) * TONE_DEN / TONE_NUM);
	localparam int SEC_CYC   = CLK_HZ;
	localparam int MS_CYC    = CLK_HZ / 1000;
	localparam int CAL_S     = 4;           // reference window, seconds
	localparam int POST_S    = 7;           // post-message budget, seconds
	localparam int MIN_HOUR  = 60;
	localparam int HOUR_DAY  = 24;

	// ------------------------------------------------------------
	// register map, byte addresses
	// ------------------------------------------------------------
	localparam logic [11:0] A_CTRL   = 12'h000;
	localparam logic [11:0] A_FREQ   = 12'h004;
	localparam logic [11:0] A_FRAME  = 12'h008;
	localparam logic [11:0] A_START  = 12'h00C;
	localparam logic [11:0] A_SET    = 12'h010;
	localparam logic [11:0] A_TIME   = 12'h014;
	localparam logic [11:0] A_STAT   = 12'h018;
	localparam logic [11:0] A_SYM    = 12'h01C;
	localparam logic [11:0] A_DOT    = 12'h020;
	localparam logic [11:0] A_LEN    = 12'h024;
	localparam logic [11:0] A_TRIM   = 12'h028;
	localparam logic [11:0] A_LOC    = 12'h02C;

	// field positions
	localparam int CTRL_EN    = 0;
	localparam int CTRL_WSPR  = 1;
	localparam int CTRL_MENU  = 8;
	localparam int CTRL_STOP  = 9;
	localparam int STAT_UNDER = 4;
	localparam int HOUR_LSB   = 16;
	localparam int MIN_LSB    = 8;

	// values after reset
	localparam logic [31:0] FREQ_RST  = 32'h0000_0000;
	localparam logic [5:0]  FRAME_RST = 6'h0A;
	localparam logic [5:0]  START_RST = 6'h04;
	localparam logic [15:0] DOT_RST   = 16'h0064;
	localparam logic [7:0]  LEN_RST   = 8'h10;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_TX   = 2'b11,
		ST_POST = 2'b10
	} state_type;
endpackage

// *** core/beacon_tone_sequencer.sv ***
// beacon frame scheduler, symbol stepper, clock and reference calibration,
// with its AXI4-Lite registers and a symbol FIFO
// assumes a gps sentence parser on clk; pps and exit arrive as raw pins
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns

// ------------------------------------------------------------
// symbol FIFO
// ------------------------------------------------------------
module beacon_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_q;
	logic [AW:0]      rdPtr_q;

	// extra pointer bit tells full from empty
	assign inReady  = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData  = mem[rdPtr_q[AW-1:0]];

	// storage
	always_ff @(posedge clk) begin
		if (inValid && inReady) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	// pointers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (inValid && inReady) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (outValid && outReady) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end
endmodule

// ------------------------------------------------------------
// sequencer
// ------------------------------------------------------------
module beacon_tone_sequencer #(
	parameter int SYM_CYCLES = beacon_pkg::SYM_CYC,
	parameter int SEC_CYCLES = beacon_pkg::SEC_CYC,
	parameter int MS_CYCLES  = beacon_pkg::MS_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        ppsPin,
	input  wire logic        exitPin,
	input  wire logic        beaconStrap,
	input  wire logic        gpsValid,
	input  wire logic [4:0]  gpsHour,
	input  wire logic [5:0]  gpsMin,
	input  wire logic [5:0]  gpsSec,
	input  wire logic [7:0]  gpsLatDeg,
	input  wire logic [8:0]  gpsLonDeg,
	output logic             txKey,
	output logic [45:0]      freqOut,
	output logic [7:0]       symIdx,
	output logic [1:0]       toneVal,
	output logic [31:0]      refTrim,
	output logic [4:0]       clkHour,
	output logic [5:0]       clkMin,
	output logic [5:0]       nextMin
);
	import beacon_pkg::*;
	localparam int CAL_CYCLES = CAL_S * SEC_CYCLES;

	state_type   state_q;
	logic [1:0]  ppsSync_q;
	logic [1:0]  exitSync_q;
	logic [1:0]  strapSync_q;
	logic        ppsLast_q;
	logic        exitLast_q;
	logic        awHave_q;
	logic        wHave_q;
	logic [11:0] wrAddr_q;
	logic [31:0] wData_q;
	logic [3:0]  wStrb_q;
	logic        bvalid_q;
	logic        bresp_q;
	logic        rvalid_q;
	logic        rresp_q;
	logic [31:0] rdata_q;
	logic        enable_q;
	logic        modeWspr_q;
	logic [31:0] freqBase_q;
	logic [5:0]  frame_q;
	logic [5:0]  startMin_q;
	logic [15:0] dotMs_q;
	logic [7:0]  msgLen_q;
	logic        underrun_q;
	logic        bootPend_q;
	logic        bootGo_q;
	logic [31:0] secCnt_q;
	logic [5:0]  clkSec_q;
	logic [31:0] symTmr_q;
	logic [31:0] postCnt_q;
	logic        calRun_q;
	logic [31:0] calCyc_q;
	logic [31:0] calN_q;
	logic [31:0] locator_q;
	logic        ppsEdge;
	logic        exitGo;
	logic        wrDo;
	logic        wrFire;
	logic        wrOk;
	logic        rdOk;
	logic [31:0] rdVal;
	logic [31:0] wMask;
	logic        menuGo;
	logic        setGo;
	logic        secTick;
	logic        gpsTake;
	logic        fifoInReady;
	logic        fifoValid;
	logic [1:0]  fifoData;
	logic        load;
	logic        symEnd;
	logic        lastSym;
	logic [31:0] unitLast;
	logic [6:0]  advSum;
	logic [5:0]  nextAdv;
	logic [8:0]  lonP;
	logic [7:0]  latP;

	// ------------------------------------------------------------
	// pins and register bus
	// ------------------------------------------------------------
	// two flops per pin; only the second feeds edge logic
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ppsSync_q  <= 2'h0;
			exitSync_q <= 2'h0;
			ppsLast_q  <= 1'b0;
			exitLast_q <= 1'b0;
		end else begin
			ppsSync_q  <= {ppsSync_q[0], ppsPin};
			exitSync_q <= {exitSync_q[0], exitPin};
			ppsLast_q  <= ppsSync_q[1];
			exitLast_q <= exitSync_q[1];
		end
	end
	assign ppsEdge = ppsSync_q[1] && !ppsLast_q;

	// strap is a pin too; no reset here, so its level has settled by the time reset lets go
	always_ff @(posedge clk) begin
		strapSync_q <= {strapSync_q[0], beaconStrap};
	end

	// a symbol write waits while the FIFO is full, so bresp stalls too
	assign wrDo    = awHave_q && wHave_q && !bvalid_q;
	assign wrFire  = wrDo && (wrAddr_q != A_SYM || fifoInReady);
	assign wMask   = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
	assign menuGo  = wrFire && wrAddr_q == A_CTRL && wData_q[CTRL_MENU];
	assign setGo   = wrFire && wrAddr_q == A_SET;
	assign exitGo  = (exitSync_q[1] && !exitLast_q) || (wrFire && wrAddr_q == A_CTRL && wData_q[CTRL_STOP]);
	assign awready = !awHave_q;
	assign wready  = !wHave_q;
	assign bvalid  = bvalid_q;
	assign bresp   = {bresp_q, 1'b0};
	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rresp   = {rresp_q, 1'b0};
	assign rdata   = rdata_q;

	// write decode
	always_comb begin
		if (wrAddr_q == A_CTRL || wrAddr_q == A_FREQ || wrAddr_q == A_FRAME || wrAddr_q == A_START) begin
			wrOk = 1'b1;
		end else if (wrAddr_q == A_SET || wrAddr_q == A_STAT || wrAddr_q == A_SYM) begin
			wrOk = 1'b1;
		end else if (wrAddr_q == A_DOT || wrAddr_q == A_LEN) begin
			wrOk = 1'b1;
		end else begin
			wrOk = 1'b0;
		end
	end

	// write channel capture and response
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			awHave_q <= 1'b0;
			wHave_q  <= 1'b0;
			wrAddr_q <= 12'h000;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= 1'b0;
		end else begin
			if (awvalid && !awHave_q) begin
				awHave_q <= 1'b1;
				wrAddr_q <= awaddr;
			end
			if (wvalid && !wHave_q) begin
				wHave_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (wrFire) begin
				awHave_q <= 1'b0;
				wHave_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= !wrOk;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read decode; unmapped addresses answer zero with SLVERR
	always_comb begin
		rdOk  = 1'b1;
		rdVal = 32'h0000_0000;
		if (araddr == A_CTRL) begin
			rdVal = {30'h0, modeWspr_q, enable_q};
		end else if (araddr == A_FREQ) begin
			rdVal = freqBase_q;
		end else if (araddr == A_FRAME) begin
			rdVal = {26'h0, frame_q};
		end else if (araddr == A_START) begin
			rdVal = {26'h0, startMin_q};
		end else if (araddr == A_TIME) begin
			rdVal = {11'h0, clkHour, 2'h0, clkMin, 2'h0, clkSec_q};
		end else if (araddr == A_STAT) begin
			rdVal = {2'h0, nextMin, 6'h0, toneVal, symIdx, 3'h0, underrun_q, 2'h0, state_q};
		end else if (araddr == A_DOT) begin
			rdVal = {16'h0, dotMs_q};
		end else if (araddr == A_LEN) begin
			rdVal = {24'h0, msgLen_q};
		end else if (araddr == A_TRIM) begin
			rdVal = refTrim;
		end else if (araddr == A_LOC) begin
			rdVal = locator_q;
		end else if (araddr != A_SET && araddr != A_SYM) begin
			rdOk = 1'b0;
		end
	end

	// read channel
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rvalid_q <= 1'b0;
			rresp_q  <= 1'b0;
			rdata_q  <= 32'h0000_0000;
		end else if (arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q  <= !rdOk;
			rdata_q  <= rdVal;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// configuration; enable is caught from the strap after reset release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable_q   <= 1'b0;
			modeWspr_q <= 1'b1;
			freqBase_q <= FREQ_RST;
			frame_q    <= FRAME_RST;
			startMin_q <= START_RST;
			dotMs_q    <= DOT_RST;
			msgLen_q   <= LEN_RST;
			bootPend_q <= 1'b1;
			bootGo_q   <= 1'b0;
		end else begin
			bootPend_q <= 1'b0;
			bootGo_q   <= bootPend_q;
			if (bootPend_q) begin
				enable_q <= strapSync_q[1];
			end else if (wrFire && wrAddr_q == A_CTRL && wStrb_q[0]) begin
				enable_q   <= wData_q[CTRL_EN];
				modeWspr_q <= wData_q[CTRL_WSPR];
			end
			if (wrFire && wrAddr_q == A_FREQ) begin
				freqBase_q <= (freqBase_q & ~wMask) | (wData_q & wMask);
			end
			if (wrFire && wrAddr_q == A_FRAME && wStrb_q[0]) begin
				frame_q <= wData_q[5:0];
			end
			if (wrFire && wrAddr_q == A_START && wStrb_q[0]) begin
				startMin_q <= wData_q[5:0];
			end
			if (wrFire && wrAddr_q == A_DOT) begin
				dotMs_q <= (dotMs_q & ~wMask[15:0]) | (wData_q[15:0] & wMask[15:0]);
			end
			if (wrFire && wrAddr_q == A_LEN && wStrb_q[0]) begin
				msgLen_q <= wData_q[7:0];
			end
		end
	end

	beacon_fifo #(
		.WIDTH(2),
		.DEPTH(16)
	) symFifo (
		.clk     (clk),
		.sys_rst (sys_rst),
		.inData  (wData_q[1:0]),
		.inValid (wrDo && wrAddr_q == A_SYM),
		.inReady (fifoInReady),
		.outData (fifoData),
		.outValid(fifoValid),
		.outReady(load)
	);

	// ------------------------------------------------------------
	// real-time clock
	// ------------------------------------------------------------
	assign secTick = secCnt_q == 32'(SEC_CYCLES - 1);
	assign gpsTake = state_q == ST_POST && gpsValid;

	// manual setting first, then gps, then the seconds tick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			secCnt_q <= 32'h0;
			clkSec_q <= 6'h0;
			clkMin   <= 6'h0;
			clkHour  <= 5'h0;
		end else if (setGo) begin
			secCnt_q <= 32'h0;
			clkSec_q <= 6'h0;
			clkMin   <= wData_q[MIN_LSB +: 6];
			clkHour  <= wData_q[HOUR_LSB +: 5];
		end else if (gpsTake) begin
			secCnt_q <= 32'h0;
			clkSec_q <= gpsSec;
			clkMin   <= gpsMin;
			clkHour  <= gpsHour;
		end else if (secTick) begin
			secCnt_q <= 32'h0;
			clkSec_q <= (clkSec_q == 6'(MIN_HOUR - 1)) ? 6'h0 : clkSec_q + 6'h1;
			if (clkSec_q == 6'(MIN_HOUR - 1)) begin
				clkMin <= (clkMin == 6'(MIN_HOUR - 1)) ? 6'h0 : clkMin + 6'h1;
				if (clkMin == 6'(MIN_HOUR - 1)) begin
					clkHour <= (clkHour == 5'(HOUR_DAY - 1)) ? 5'h0 : clkHour + 5'h1;
				end
			end
		end else begin
			secCnt_q <= secCnt_q + 32'h1;
		end
	end

	// locator square from whole degrees; lat and lon are signed
	assign lonP = gpsLonDeg + 9'd180;
	assign latP = gpsLatDeg + 8'd90;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			locator_q <= 32'h4141_3030;
		end else if (gpsTake) begin
			locator_q <= {8'h41 + 8'(lonP / 9'd20), 8'h41 + latP / 8'd10,
				8'h30 + 8'((lonP % 9'd20) / 9'd2), 8'h30 + latP % 8'd10};
		end
	end

	// ------------------------------------------------------------
	// frame scheduler and symbol stepper
	// ------------------------------------------------------------
	assign advSum   = {1'b0, nextMin} + {1'b0, frame_q};
	assign nextAdv  = (advSum >= 7'(MIN_HOUR)) ? 6'(advSum - 7'(MIN_HOUR)) : advSum[5:0];
	assign unitLast = modeWspr_q ? 32'(SYM_CYCLES - 1)
		: 32'((dotMs_q == 16'h0 ? 32'h1 : {16'h0, dotMs_q}) * MS_CYCLES - 1);
	assign symEnd   = symTmr_q == unitLast;
	assign lastSym  = symIdx == (modeWspr_q ? 8'(SYM_COUNT - 1) : msgLen_q - 8'h1);
	assign load     = (state_q == ST_WAIT && secCnt_q == 32'h0 && clkSec_q == 6'h0 && clkMin == nextMin
		&& !(modeWspr_q && clkMin[0]) && !exitGo) || (state_q == ST_TX && symEnd && !lastSym && !exitGo);

	// state, index, timers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q   <= ST_IDLE;
			nextMin   <= START_RST;
			symIdx    <= 8'h0;
			symTmr_q  <= 32'h0;
			postCnt_q <= 32'h0;
		end else if (exitGo) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (enable_q && (menuGo || bootGo_q)) begin
						state_q <= ST_WAIT;
						nextMin <= startMin_q;
					end
				end
				ST_WAIT: begin
					if (load) begin
						state_q  <= ST_TX;
						symIdx   <= 8'h0;
						symTmr_q <= 32'h0;
					end else if (secCnt_q == 32'h0 && clkSec_q == 6'h0 && clkMin == nextMin) begin
						nextMin <= nextAdv;
					end
				end
				ST_TX: begin
					symTmr_q <= symEnd ? 32'h0 : symTmr_q + 32'h1;
					if (symEnd && lastSym) begin
						state_q   <= ST_POST;
						postCnt_q <= 32'h0;
						nextMin   <= nextAdv;
					end else if (symEnd) begin
						symIdx <= symIdx + 8'h1;
					end
				end
				ST_POST: begin
					postCnt_q <= postCnt_q + 32'h1;
					if (postCnt_q == 32'(CAL_CYCLES - 1)) begin
						state_q <= ST_WAIT;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// tone taken from the FIFO; an empty FIFO sends tone 0 and flags it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			toneVal    <= 2'h0;
			underrun_q <= 1'b0;
		end else begin
			if (load) begin
				toneVal <= fifoValid ? fifoData : 2'h0;
			end
			if (load && !fifoValid) begin
				underrun_q <= 1'b1;
			end else if (wrFire && wrAddr_q == A_STAT && wData_q[STAT_UNDER]) begin
				underrun_q <= 1'b0;
			end
		end
	end

	// key and output frequency; base is tone 0 with nothing added
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txKey   <= 1'b0;
			freqOut <= 46'h0;
		end else begin
			txKey   <= state_q == ST_TX && !exitGo && (modeWspr_q || toneVal[0]);
			freqOut <= 46'({freqBase_q, 13'h0}) + 46'(modeWspr_q ? toneVal : 2'h0) * 46'(TONE_NUM);
		end
	end

	// reference: cycles between pps edges in the post window
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			calRun_q <= 1'b0;
			calCyc_q <= 32'h0;
			calN_q   <= 32'h0;
			refTrim  <= 32'h0;
		end else if (state_q != ST_POST) begin
			calRun_q <= 1'b0;
			calCyc_q <= 32'h0;
			calN_q   <= 32'h0;
		end else if (ppsEdge) begin
			calRun_q <= 1'b1;
			calCyc_q <= calCyc_q + 32'h1;
			if (calRun_q) begin
				calN_q  <= calN_q + 32'h1;
				refTrim <= calCyc_q - (calN_q + 32'h1) * 32'(SEC_CYCLES);
			end
		end else if (calRun_q) begin
			calCyc_q <= calCyc_q + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_txEnter;
		$rose(state_q == ST_TX);
	endsequence
	sequence s_postEnter;
		$rose(state_q == ST_POST);
	endsequence
	property p_len;
		s_postEnter and modeWspr_q |-> $past(symIdx) == 8'(SYM_COUNT - 1);
	endproperty
	a_len: assert property (p_len) else $error("message not 162 symbols");
	property p_tone;
		state_q == ST_TX && modeWspr_q ##1 $stable(toneVal) && $stable(freqBase_q)
			|-> freqOut == 46'({freqBase_q, 13'h0}) + 46'(toneVal) * 46'(TONE_NUM);
	endproperty
	a_tone: assert property (p_tone) else $error("tone frequency wrong");
	property p_hold;
		state_q == ST_TX && $past(state_q) == ST_TX && modeWspr_q && $changed(symIdx)
			|-> $past(symTmr_q) == 32'(SYM_CYCLES - 1);
	endproperty
	a_hold: assert property (p_hold) else $error("symbol duration wrong");
	property p_even;
		s_txEnter |-> !modeWspr_q || (!clkMin[0] && clkSec_q == 6'h0);
	endproperty
	a_even: assert property (p_even) else $error("message off even minute");
	property p_next;
		s_postEnter |-> int'(nextMin) == (int'($past(nextMin)) + int'(frame_q)) % MIN_HOUR;
	endproperty
	a_next: assert property (p_next) else $error("next start not one interval on");
	property p_gps;
		state_q == ST_TX |=> $stable(locator_q) ##0 ($stable(clkHour) || $past(secTick));
	endproperty
	a_gps: assert property (p_gps) else $error("gps taken during message");
	property p_post;
		$fell(state_q == ST_POST) && !$past(exitGo) |-> $past(postCnt_q) == 32'(CAL_CYCLES - 1);
	endproperty
	a_post: assert property (p_post) else $error("post window length wrong");
	property p_exit;
		exitGo |=> state_q == ST_IDLE && !txKey ##1 !txKey;
	endproperty
	a_exit: assert property (p_exit) else $error("exit did not stop beacon");
	property p_set;
		setGo |=> clkSec_q == 6'h0 && secCnt_q == 32'h0;
	endproperty
	a_set: assert property (p_set) else $error("clock set left seconds");
	property p_key;
		s_txEnter |-> symIdx == 8'h0 ##1 (txKey || !modeWspr_q || $past(exitGo));
	endproperty
	a_key: assert property (p_key) else $error("message start not keyed");
endmodule

// *** tb/gps_model.sv ***
// gps_model: stand-in for the gps receiver, giving pps pulses and parsed sentences
// assumes the same clk as the sequencer; sentences are sent on command from the bench
`timescale 1ns/1ns
module gps_model #(
	parameter int PPS_CYC = 103
) (
	input  wire logic clk,
	output logic      ppsPin,
	output logic      gpsValid,
	output logic [4:0] gpsHour,
	output logic [5:0] gpsMin,
	output logic [5:0] gpsSec,
	output logic [7:0] gpsLatDeg,
	output logic [8:0] gpsLonDeg
);
	int ppsCnt = 0;
	initial begin
		{ppsPin, gpsValid, gpsHour, gpsMin, gpsSec, gpsLatDeg, gpsLonDeg} = '0;
	end
	// pps runs slightly slow so the trim measurement has a drift to see
	always @(posedge clk) begin
		ppsCnt <= (ppsCnt == PPS_CYC - 1) ? 0 : ppsCnt + 1;
		ppsPin <= (ppsCnt < 10);
	end
	// one sentence; fields are scrambled after it so stale data never looks right
	task automatic send(input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
		@(posedge clk);
		{gpsHour, gpsMin, gpsSec, gpsLatDeg, gpsLonDeg} <= {h, m, s, 8'h33, 9'h000};
		gpsValid <= 1'h1;
		@(posedge clk);
		gpsValid <= 1'h0;
		{gpsHour, gpsMin, gpsSec, gpsLatDeg, gpsLonDeg} <= ~{h, m, s, 8'h33, 9'h000};
	endtask
endmodule

// *** tb/tb_top.sv ***
// tb_top: self-checking bench for the beacon sequencer with shortened timing
// assumes gps_model beside it and the register map of beacon_pkg
`timescale 1ns/1ns
module tb_top;
	import beacon_pkg::*;
	localparam int SYM_C = 20;
	localparam logic [31:0] BASE = 32'h00D7_1AF4;
	logic        clk = 1'h0;
	logic        sysRst = 1'h1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, refTrim, rd;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        exitPin = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, ppsPin, gpsValid, txKey;
	logic [1:0]  bresp, rresp, toneVal, rs;
	logic [4:0]  gpsHour, clkHour;
	logic [5:0]  gpsMin, gpsSec, clkMin, nextMin;
	logic [7:0]  gpsLatDeg, symIdx;
	logic [8:0]  gpsLonDeg;
	logic [45:0] freqOut;
	int          mismatches = 0, n_compared = 0, nWr = 0;

	always #5 clk = ~clk;

	beacon_tone_sequencer #(.SYM_CYCLES(SYM_C), .SEC_CYCLES(100), .MS_CYCLES(2)) beacon_tone_sequencer_inst (
		.clk, .sys_rst(sysRst), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.ppsPin, .exitPin, .beaconStrap(1'h1), .gpsValid, .gpsHour, .gpsMin, .gpsSec, .gpsLatDeg,
		.gpsLonDeg, .txKey, .freqOut, .symIdx, .toneVal, .refTrim, .clkHour, .clkMin, .nextMin);
	gps_model gps_model_inst (.clk, .ppsPin, .gpsValid, .gpsHour, .gpsMin, .gpsSec, .gpsLatDeg, .gpsLonDeg);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [45:0] exp, input logic [45:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// address and data go out together; bready stays up until the answer
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!done) begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'h0;
				done = 1;
			end
		end
		nWr++;
	endtask
	task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	// bounded wait; the caller judges the level afterwards
	task automatic waitKey(input logic lvl, input int lim);
		for (int n = 0; n < lim && txKey !== lvl; n++) @(posedge clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rdr(A_STAT, rd, rs);
		chk("state after reset", 2'h1, rd[1:0]);
		chk("nextMin", START_RST, nextMin);
		rdr(A_FRAME, rd, rs);
		chk("frame", FRAME_RST, rd[5:0]);
		rdr(12'h0FC, rd, rs);
		chk("unmapped read", 2'h2, rs);
		wr(12'h0FC, 32'h1, rs);
		chk("unmapped write", 2'h2, rs);
		wr(A_SET, 32'h0000_0300, rs);
		rdr(A_TIME, rd, rs);
		chk("seconds", 6'h00, rd[5:0]);
		chk("minutes", 6'h03, clkMin);
		$display("test regs done");
	endtask
	// gps in wait is ignored, fifo fills and refuses, then a whole message
	task automatic t_wspr;
		logic [31:0] tone;
		wr(A_FREQ, BASE, rs);
		gps_model_inst.send(5'h07, 6'h03, 6'h00);
		nWr = 0;
		fork
			for (int i = 0; i < 18; i++) wr(A_SYM, i % 4, rs);
			begin
				repeat (2000) @(posedge clk);
				chk("fifo writes taken", 16, nWr);
				chk("hour after early gps", 5'h00, clkHour);
				waitKey(1'h1, 7000);
				chk("minute at start", 6'h04, clkMin);
				repeat (SYM_C / 2) @(posedge clk);
				for (int i = 0; i < SYM_COUNT; i++) begin
					tone = (i < 18) ? i % 4 : 0;
					#1;
					chk("symIdx", i, symIdx);
					chk("toneVal", tone, toneVal);
					chk("freqOut", BASE * 46'h2000 + tone * TONE_NUM, freqOut);
					chk("txKey", 1'h1, txKey);
					repeat (SYM_C) @(posedge clk);
				end
			end
		join
		waitKey(1'h0, 50);
		chk("txKey after message", 1'h0, txKey);
		rdr(A_STAT, rd, rs);
		chk("post state", 2'h2, rd[1:0]);
		gps_model_inst.send(5'h00, 6'h0D, 6'h37);
		repeat (3) @(posedge clk);
		chk("gps minute", 6'h0D, clkMin);
		repeat (400) @(posedge clk);
		rdr(A_STAT, rd, rs);
		chk("wait after post", 2'h1, rd[1:0]);
		chk("next start", 6'h0E, nextMin);
		chk("trim value", 1'h1, refTrim == 32'd6 || refTrim == 32'd9);
		$display("test wspr done");
	endtask
	// exit in mid-message drops the key at once
	task automatic t_exit;
		waitKey(1'h1, 400);
		chk("txKey before exit", 1'h1, txKey);
		repeat (30) @(posedge clk);
		exitPin <= 1'h1;
		repeat (6) @(posedge clk);
		chk("txKey after exit", 1'h0, txKey);
		exitPin <= 1'h0;
		rdr(A_STAT, rd, rs);
		chk("idle after exit", 2'h0, rd[1:0]);
		$display("test exit done");
	endtask
	// keyed mode: four one-dot elements, started by menu exit and a clock set
	task automatic t_cw;
		wr(A_LEN, 32'h4, rs);
		wr(A_DOT, 32'h5, rs);
		wr(A_START, 32'hF, rs);
		for (int i = 0; i < 4; i++) wr(A_SYM, (i == 1) ? 32'h0 : 32'h1, rs);
		wr(A_CTRL, 32'h0000_0101, rs);
		wr(A_SET, 32'h0000_0F00, rs);
		repeat (6) @(posedge clk);
		for (int i = 0; i < 5; i++) begin
			#1;
			chk("cw symIdx", (i > 3) ? 3 : i, symIdx);
			chk("cw txKey", i != 1 && i < 4, txKey);
			chk("cw freqOut", BASE * 46'h2000, freqOut);
			repeat (10) @(posedge clk);
		end
		wr(A_CTRL, 32'h0000_0200, rs);
		rdr(A_STAT, rd, rs);
		chk("idle after stop", 2'h0, rd[1:0]);
		$display("test cw done");
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		sysRst <= 1'h0;
		repeat (3) @(posedge clk);
		t_regs();
		t_wspr();
		t_exit();
		t_cw();
		end_of_test();
	end
	// watchdog: the whole run needs about 10000 cycles
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule
